// ==== include/bmpc_defs.svh ====
// Clock, reset values and timing counts of the burst and protection control
`ifndef BMPC_DEFS_SVH
`define BMPC_DEFS_SVH

// Logic clock
`define BMPC_CLK_HZ          125000000
`define BMPC_CLK_MHZ         125
`define BMPC_CNT_W           22

// Times in their own units
`define BMPC_BURST_HZ        52000
`define BMPC_MAXON_NS        30000
`define BMPC_LEB_NS          330
`define BMPC_OL_BLANK_MS     24
`define BMPC_ENTRY_BLANK_MS  20
`define BMPC_OVP_BLANK_NS    1000
`define BMPC_SW_BLANK_NS     200

// Cycle counts; longest times round down, least times round up
`define BMPC_BURST_PER_CYC   (`BMPC_CLK_HZ / `BMPC_BURST_HZ)
`define BMPC_DUTY_CYC        (`BMPC_BURST_PER_CYC / 2)
`define BMPC_MAXON_CYC       (`BMPC_MAXON_NS * `BMPC_CLK_MHZ / 1000)
`define BMPC_LEB_CYC         ((`BMPC_LEB_NS * `BMPC_CLK_MHZ + 999) / 1000)
`define BMPC_OL_CYC          (`BMPC_OL_BLANK_MS * `BMPC_CLK_MHZ * 1000)
`define BMPC_ENTRY_CYC       (`BMPC_ENTRY_BLANK_MS * `BMPC_CLK_MHZ * 1000)
`define BMPC_OVP_CYC         ((`BMPC_OVP_BLANK_NS * `BMPC_CLK_MHZ + 999) / 1000)
`define BMPC_SW_CYC          ((`BMPC_SW_BLANK_NS * `BMPC_CLK_MHZ + 999) / 1000)

// Up/down counter
`define BMPC_UDCNT_RST       3'h1
`define BMPC_UDCNT_MAX       3'h7

`endif

// ==== include/bmpc_pkg.sv ====
// Types of the burst and protection control
package bmpc_pkg;

    // Comparator decisions, one bit each
    typedef struct packed {
        logic fbBelowEntry;   // Below burst_entry_level
        logic fbAboveResume;  // Above burst_resume_level
        logic fbBelowPause;   // At or below burst_pause_level
        logic fbAboveExit;    // Above burst_exit_level
        logic fbPulledHigh;   // Overload or open loop
        logic csAbovePeak;    // Normal peak current reached
        logic csAboveBurst;   // burst_peak_limit reached
        logic csShortWind;    // Above short_winding_level
        logic zcOverVolt;     // Above output_overvoltage_level
        logic supplyOver;     // Supply overvoltage
        logic supplyUnder;    // Below supply_off_level
        logic supplyAboveOn;  // Above supply_on_level
        logic overTemp;       // Junction over temperature
    } bmpc_cmp_type;

    // Operating states
    typedef enum logic [2:0] {
        ST_DRAIN,
        ST_CHARGE,
        ST_RUN,
        ST_BURST,
        ST_LATCH
    } bmpc_state_type;

endpackage

// ==== core/bmpc_sync3.sv ====
// Three-stage synchroniser with agreement filter for comparator inputs
`timescale 1ns/1ps

module bmpc_sync3
    import bmpc_pkg::*;
#(
    parameter int WIDTH = $bits(bmpc_cmp_type)
) (
    input  wire logic             ref_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] asyncIn,
    output logic      [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] stage1_ff;
    logic [WIDTH-1:0] stage2_ff;
    logic [WIDTH-1:0] stage3_ff;
    logic [WIDTH-1:0] out_ff;
    logic [WIDTH-1:0] nxt_out;

    // A bit changes only once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            nxt_out[i] = (stage2_ff[i] == stage3_ff[i]) ? stage3_ff[i]
                                                         : out_ff[i];
        end
    end

    // Register stages
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            stage1_ff <= '0;
            stage2_ff <= '0;
            stage3_ff <= '0;
            out_ff    <= '0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
            stage3_ff <= stage2_ff;
            out_ff    <= nxt_out;
        end
    end

    assign syncOut = out_ff;

endmodule // bmpc_sync3

// ==== core/bmpc_ctrl.sv ====
// Burst mode, gate timing and protection control of a flyback controller
`timescale 1ns/1ps
`include "bmpc_defs.svh"

module bmpc_ctrl
    import bmpc_pkg::*;
#(
    parameter logic [21:0] OVERLOAD_BLANK_CYC = 22'(`BMPC_OL_CYC),
    parameter logic [21:0] ENTRY_BLANK_CYC    = 22'(`BMPC_ENTRY_CYC)
) (
    input  wire logic         ref_clk,
    input  wire logic         reset,
    input  wire bmpc_cmp_type rawCmp,
    input  wire logic         zcTurnOn,
    input  wire logic         cntUp,
    input  wire logic         cntDown,
    output logic              gateOn_ff,
    output logic              startupEn_ff,
    output logic              biasEn_ff,
    output logic              burstMode_ff,
    output logic              peakSelBurst_ff,
    output logic              latchedOff_ff,
    output logic              autoRestart_ff,
    output logic              softStart_ff,
    output logic [2:0]        udCount_ff
);

    localparam logic [21:0] BURST_PER = 22'(`BMPC_BURST_PER_CYC);
    localparam logic [21:0] DUTY_CYC  = 22'(`BMPC_DUTY_CYC);
    localparam logic [21:0] MAXON_CYC = 22'(`BMPC_MAXON_CYC);
    localparam logic [21:0] LEB_CYC   = 22'(`BMPC_LEB_CYC);
    localparam logic [21:0] OVP_CYC   = 22'(`BMPC_OVP_CYC);
    localparam logic [21:0] SW_CYC    = 22'(`BMPC_SW_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisation

    logic [$bits(bmpc_cmp_type)-1:0] cmpVec;
    bmpc_cmp_type                    cmp;

    // Every comparator decision crosses into the logic clock
    bmpc_sync3 u_sync (
        .ref_clk (ref_clk),
        .reset   (reset),
        .asyncIn (rawCmp),
        .syncOut (cmpVec)
    );

    assign cmp = bmpc_cmp_type'(cmpVec);

    // Next count of a hold timer, saturating one below its limit
    function automatic logic [21:0] holdNext(input logic        cond,
                                             input logic [21:0] cnt,
                                             input logic [21:0] lim);
        if (!cond) begin
            holdNext = '0;
        end else if (cnt >= lim - 22'h000001) begin
            holdNext = cnt;
        end else begin
            holdNext = cnt + 22'h000001;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // State and timers

    bmpc_state_type state_ff;
    bmpc_state_type nxt_state;
    logic [21:0]    onCnt_ff;
    logic [21:0]    tmr_ff;
    logic [21:0]    olCnt_ff;
    logic [21:0]    entCnt_ff;
    logic [21:0]    ovpCnt_ff;
    logic [21:0]    swCnt_ff;
    logic           burstPause_ff;
    logic [21:0]    nxt_onCnt;
    logic [21:0]    nxt_tmr;
    logic [21:0]    nxt_olCnt;
    logic [21:0]    nxt_entCnt;
    logic [21:0]    nxt_ovpCnt;
    logic [21:0]    nxt_swCnt;
    logic           nxt_burstPause;
    logic           nxt_gateOn;
    logic           nxt_startupEn;
    logic           nxt_biasEn;
    logic           nxt_burstMode;
    logic           nxt_peakSelBurst;
    logic           nxt_softStart;
    logic [2:0]     nxt_udCount;
    logic           active;
    logic           latchFault;
    logic           restartFault;
    logic           onDone;

    // Protection timers and fault decisions
    always_comb begin
        active     = (state_ff == ST_RUN) || (state_ff == ST_BURST);
        nxt_olCnt  = holdNext(active && cmp.fbPulledHigh,
                              olCnt_ff, OVERLOAD_BLANK_CYC);
        nxt_ovpCnt = holdNext(active && !gateOn_ff && cmp.zcOverVolt,
                              ovpCnt_ff, OVP_CYC);
        nxt_swCnt  = holdNext(active && gateOn_ff && cmp.csShortWind,
                              swCnt_ff, SW_CYC);
        latchFault = active &&
                     ((!gateOn_ff && cmp.zcOverVolt &&
                       ovpCnt_ff == OVP_CYC - 22'h000001) ||
                      (gateOn_ff && cmp.csShortWind &&
                       swCnt_ff == SW_CYC - 22'h000001));
        restartFault = active &&
                       (cmp.supplyOver || cmp.supplyUnder ||
                        cmp.overTemp ||
                        (cmp.fbPulledHigh && olCnt_ff ==
                         OVERLOAD_BLANK_CYC - 22'h000001));
    end

    // Operating state, gate and burst sequencing
    always_comb begin
        nxt_state        = state_ff;
        nxt_gateOn       = gateOn_ff;
        nxt_startupEn    = startupEn_ff;
        nxt_biasEn       = biasEn_ff;
        nxt_burstMode    = burstMode_ff;
        nxt_burstPause   = burstPause_ff;
        nxt_peakSelBurst = peakSelBurst_ff;
        nxt_udCount      = udCount_ff;
        nxt_softStart    = 1'b0;
        nxt_tmr          = tmr_ff;
        nxt_entCnt       = '0;
        // First high cycle counts one, so the gate stands the full limit
        onDone           = (onCnt_ff == MAXON_CYC);
        unique case (state_ff)
            ST_DRAIN: begin
                nxt_gateOn    = 1'b0;
                nxt_biasEn    = 1'b0;
                nxt_startupEn = 1'b0;
                if (cmp.supplyUnder) begin
                    nxt_state     = ST_CHARGE;
                    nxt_startupEn = 1'b1;
                end
            end
            ST_CHARGE: begin
                nxt_gateOn    = 1'b0;
                nxt_startupEn = 1'b1;
                if (cmp.supplyAboveOn) begin
                    nxt_state     = ST_RUN;
                    nxt_startupEn = 1'b0;
                    nxt_biasEn    = 1'b1;
                    nxt_softStart = 1'b1;
                end
            end
            ST_RUN: begin
                // Valley-timed turn-on, peak or on-time turn-off
                if (gateOn_ff) begin
                    if ((onCnt_ff >= LEB_CYC && cmp.csAbovePeak) ||
                        onDone) begin
                        nxt_gateOn = 1'b0;
                    end
                end else if (zcTurnOn) begin
                    nxt_gateOn = 1'b1;
                end
                // Up/down counter saturates between one and seven
                if (cntUp && !cntDown && udCount_ff != `BMPC_UDCNT_MAX) begin
                    nxt_udCount = udCount_ff + 3'h1;
                end else if (cntDown && !cntUp &&
                             udCount_ff != `BMPC_UDCNT_RST) begin
                    nxt_udCount = udCount_ff - 3'h1;
                end
                nxt_entCnt = holdNext(cmp.fbBelowEntry &&
                                      udCount_ff == `BMPC_UDCNT_MAX,
                                      entCnt_ff, ENTRY_BLANK_CYC);
                if (cmp.fbBelowEntry && udCount_ff == `BMPC_UDCNT_MAX &&
                    entCnt_ff == ENTRY_BLANK_CYC - 22'h000001) begin
                    nxt_state        = ST_BURST;
                    nxt_burstMode    = 1'b1;
                    nxt_burstPause   = 1'b1;
                    nxt_biasEn       = 1'b0;
                    nxt_gateOn       = 1'b0;
                    nxt_peakSelBurst = 1'b1;
                end
            end
            ST_BURST: begin
                if (cmp.fbAboveExit) begin
                    nxt_state        = ST_RUN;
                    nxt_burstMode    = 1'b0;
                    nxt_burstPause   = 1'b0;
                    nxt_biasEn       = 1'b1;
                    nxt_gateOn       = 1'b0;
                    nxt_peakSelBurst = 1'b0;
                    nxt_udCount      = `BMPC_UDCNT_RST;
                end else if (burstPause_ff) begin
                    nxt_gateOn = 1'b0;
                    if (cmp.fbAboveResume) begin
                        nxt_burstPause = 1'b0;
                        nxt_biasEn     = 1'b1;
                        nxt_tmr        = BURST_PER - 22'h000001;
                    end
                end else if (cmp.fbBelowPause) begin
                    nxt_burstPause = 1'b1;
                    nxt_biasEn     = 1'b0;
                    nxt_gateOn     = 1'b0;
                end else begin
                    nxt_tmr = (tmr_ff >= BURST_PER - 22'h000001) ? '0
                              : tmr_ff + 22'h000001;
                    // Whichever turn-off cause comes first wins
                    if (gateOn_ff) begin
                        if ((onCnt_ff >= LEB_CYC && cmp.csAboveBurst) ||
                            onCnt_ff == DUTY_CYC ||
                            onDone) begin
                            nxt_gateOn = 1'b0;
                        end
                    end else if (tmr_ff >= BURST_PER - 22'h000001) begin
                        nxt_gateOn = 1'b1;
                    end
                end
            end
            ST_LATCH: begin
                nxt_gateOn = 1'b0;
                nxt_biasEn = 1'b0;
                if (cmp.supplyUnder) begin
                    nxt_startupEn = 1'b1;
                end else if (cmp.supplyAboveOn) begin
                    nxt_startupEn = 1'b0;
                end
            end
        endcase
        // Fault responses override normal sequencing
        if (latchFault || restartFault) begin
            nxt_state        = latchFault ? ST_LATCH : ST_DRAIN;
            nxt_gateOn       = 1'b0;
            nxt_biasEn       = 1'b0;
            nxt_startupEn    = 1'b0;
            nxt_burstMode    = 1'b0;
            nxt_burstPause   = 1'b0;
            nxt_peakSelBurst = 1'b0;
            nxt_udCount      = `BMPC_UDCNT_RST;
        end
        nxt_onCnt = nxt_gateOn ? onCnt_ff + 22'h000001 : '0;
    end

    // Register all state; only a full reset leaves the latched state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_ff        <= ST_CHARGE;
            gateOn_ff       <= 1'b0;
            startupEn_ff    <= 1'b1;
            biasEn_ff       <= 1'b0;
            burstMode_ff    <= 1'b0;
            burstPause_ff   <= 1'b0;
            peakSelBurst_ff <= 1'b0;
            latchedOff_ff   <= 1'b0;
            autoRestart_ff  <= 1'b1;
            softStart_ff    <= 1'b0;
            udCount_ff      <= `BMPC_UDCNT_RST;
            onCnt_ff        <= '0;
            tmr_ff          <= '0;
            olCnt_ff        <= '0;
            entCnt_ff       <= '0;
            ovpCnt_ff       <= '0;
            swCnt_ff        <= '0;
        end else begin
            state_ff        <= nxt_state;
            gateOn_ff       <= nxt_gateOn;
            startupEn_ff    <= nxt_startupEn;
            biasEn_ff       <= nxt_biasEn;
            burstMode_ff    <= nxt_burstMode;
            burstPause_ff   <= nxt_burstPause;
            peakSelBurst_ff <= nxt_peakSelBurst;
            latchedOff_ff   <= (nxt_state == ST_LATCH);
            autoRestart_ff  <= (nxt_state == ST_DRAIN) ||
                               (nxt_state == ST_CHARGE);
            softStart_ff    <= nxt_softStart;
            udCount_ff      <= nxt_udCount;
            onCnt_ff        <= nxt_onCnt;
            tmr_ff          <= nxt_tmr;
            olCnt_ff        <= nxt_olCnt;
            entCnt_ff       <= nxt_entCnt;
            ovpCnt_ff       <= nxt_ovpCnt;
            swCnt_ff        <= nxt_swCnt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence burstExitSeen;
        burstMode_ff && cmp.fbAboveExit && !latchFault && !restartFault;
    endsequence

    sequence supplyFaultSeen;
        active && !latchFault && (cmp.supplyOver || cmp.supplyUnder);
    endsequence

    latch_gate_off_a: assert property (
        latchedOff_ff |-> !gateOn_ff && !biasEn_ff)
        else $error("gate active while latched off");

    latch_sticky_a: assert property (
        latchedOff_ff |=> latchedOff_ff)
        else $error("latched state left without reset");

    max_on_a: assert property (
        gateOn_ff |-> onCnt_ff <= MAXON_CYC)
        else $error("gate high beyond maximum on-time");

    burst_duty_a: assert property (
        (burstMode_ff && gateOn_ff) |-> onCnt_ff <= DUTY_CYC)
        else $error("burst gate beyond half period");

    burst_exit_a: assert property (
        burstExitSeen |=> !burstMode_ff && !peakSelBurst_ff &&
                          udCount_ff == 3'h1)
        else $error("burst exit did not restore limit and counter");

    supply_fault_a: assert property (
        supplyFaultSeen |=> !gateOn_ff && !latchedOff_ff && autoRestart_ff)
        else $error("supply fault did not reset with gate off");

    pause_gate_a: assert property (
        burstPause_ff |-> !gateOn_ff && !biasEn_ff)
        else $error("switching while burst paused");

    burst_turnon_a: assert property (
        (burstMode_ff && $rose(gateOn_ff)) |-> tmr_ff == 22'h000000)
        else $error("burst turn-on not on timer wrap");

    latch_startup_a: assert property (
        (latchedOff_ff && cmp.supplyUnder) |=> startupEn_ff)
        else $error("startup path not enabled while latched");

    burst_entry_a: assert property (
        ($rose(burstMode_ff) && !reset) |->
            $past(udCount_ff) == 3'h7 && $past(cmp.fbBelowEntry))
        else $error("burst entered without entry conditions");

endmodule // bmpc_ctrl

// ==== testbench/bmpc_power_model.sv ====
// Behavioural power stage: sensed current ramps while the gate is on
`timescale 1ns/1ps

module bmpc_power_model (
    input  wire logic        ref_clk,
    input  wire logic        gateOn,
    input  wire logic [15:0] rampCyc,
    input  wire logic        shortWind,
    output logic             csAboveBurst,
    output logic             csAbovePeak,
    output logic             csShortWind
);
    logic [15:0] onCnt;

    // On-time counter; the current collapses once the switch opens
    always_ff @(posedge ref_clk) begin
        if (!gateOn)
            onCnt <= 16'h0000;
        else
            onCnt <= onCnt + 16'h0001;
    end

    // Zero ramp: current never reaches a limit; peak needs twice the time
    assign csAboveBurst = gateOn && (rampCyc != 16'h0000)
                          && (onCnt >= rampCyc);
    assign csAbovePeak  = csAboveBurst && (onCnt >= {rampCyc[14:0], 1'b0});
    assign csShortWind  = gateOn && shortWind;

endmodule // bmpc_power_model

// ==== testbench/tb_top.sv ====
// Self-checking bench of the burst and protection control
`timescale 1ns/1ps

module tb_top
    import bmpc_pkg::*;
;
    logic         ref_clk;
    logic         reset;
    bmpc_cmp_type cmp;
    bmpc_cmp_type rawCmp;
    logic         zcTurnOn;
    logic         cntUp;
    logic         cntDown;
    logic [15:0]  rampCyc;
    logic         shortWind;
    logic         csB;
    logic         csP;
    logic         csS;
    logic         gateOn;
    logic         startupEn;
    logic         biasEn;
    logic         burstMode;
    logic         peakSel;
    logic         latchedOff;
    logic         autoRestart;
    logic         softStart;
    logic [2:0]   udCount;
    logic [6:0]   st;
    int           err_total;
    int           checks;

    // Status word: gate, startup, bias, burst, peak select, latch, restart
    assign st = {gateOn, startupEn, biasEn, burstMode, peakSel, latchedOff,
                 autoRestart};

    // Current sense bits come from the power stage model
    always_comb begin
        rawCmp = cmp;
        rawCmp.csAboveBurst = csB;
        rawCmp.csAbovePeak = csP;
        rawCmp.csShortWind = csS;
    end

    // Short blanking counts keep the run brief
    bmpc_ctrl #(
        .OVERLOAD_BLANK_CYC(22'h000032),
        .ENTRY_BLANK_CYC   (22'h000014)
    ) u_bmpc_ctrl (
        .ref_clk(ref_clk), .reset(reset), .rawCmp(rawCmp),
        .zcTurnOn(zcTurnOn), .cntUp(cntUp), .cntDown(cntDown),
        .gateOn_ff(gateOn), .startupEn_ff(startupEn), .biasEn_ff(biasEn),
        .burstMode_ff(burstMode), .peakSelBurst_ff(peakSel),
        .latchedOff_ff(latchedOff), .autoRestart_ff(autoRestart),
        .softStart_ff(softStart), .udCount_ff(udCount)
    );

    bmpc_power_model u_bmpc_power_model (
        .ref_clk(ref_clk), .gateOn(gateOn), .rampCyc(rampCyc),
        .shortWind(shortWind), .csAboveBurst(csB), .csAbovePeak(csP),
        .csShortWind(csS)
    );

    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////
    // Helpers
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("Error t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    task automatic end_of_test();
        $display("Checks %0d, errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic doReset();
        reset = 1'b1;
        cmp = '0;
        tick(2);
        reset = 1'b0;
        check(st, 7'h21);
        check(udCount, 3'h1);
    endtask

    task automatic pulseOn();
        zcTurnOn = 1'b1;
        tick(1);
        zcTurnOn = 1'b0;
    endtask

    task automatic gateLow(output int l);
        l = 0;
        while (gateOn !== 1'b1 && l < 5000) begin
            tick(1);
            l++;
        end
        if (l >= 5000)
            err_total++;
    endtask

    task automatic gateHigh(output int w);
        int n;
        gateLow(n);
        w = 0;
        while (gateOn === 1'b1 && w < 5000) begin
            tick(1);
            w++;
        end
        if (w >= 5000)
            err_total++;
    endtask

    task automatic powerUp();
        int p;
        p = 0;
        cmp.supplyUnder = 1'b0;
        cmp.supplyAboveOn = 1'b1;
        repeat (10) begin
            tick(1);
            if (softStart === 1'b1)
                p++;
        end
        check(p, 32'h1);
        check(st, 7'h10);
    endtask

    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic sMaxOn();
        int w;
        rampCyc = 16'h0000;
        pulseOn();
        gateHigh(w);
        check(w, 32'hEA6);
    endtask

    task automatic sFaults();
        cmp.fbPulledHigh = 1'b1;
        tick(30);
        cmp.fbPulledHigh = 1'b0;
        tick(60);
        check(st, 7'h10);
        for (int i = 0; i < 4; i++) begin
            pulseOn();
            cmp.overTemp = (i == 0);
            cmp.supplyOver = (i == 1);
            cmp.supplyUnder = (i == 2);
            cmp.fbPulledHigh = (i == 3);
            cmp.supplyAboveOn = 1'b0;
            tick(70);
            check({gateOn, autoRestart}, 2'h1);
            cmp.overTemp = 1'b0;
            cmp.supplyOver = 1'b0;
            cmp.fbPulledHigh = 1'b0;
            cmp.supplyUnder = 1'b1;
            tick(6);
            check(st, 7'h21);
            powerUp();
        end
    endtask

    task automatic sBurst();
        int w;
        int l;
        int n;
        // Count up into saturation, one step down, then back up to seven
        for (int i = 0; i < 9; i++) begin
            cntUp = (i != 7);
            cntDown = (i == 7);
            tick(1);
            cntUp = 1'b0;
            cntDown = 1'b0;
            tick(1);
            if (i == 7)
                check(udCount, 3'h6);
        end
        check(udCount, 3'h7);
        cmp.fbBelowEntry = 1'b1;
        tick(15);
        check(burstMode, 1'b0);
        tick(20);
        check(st, 7'h0C);
        cmp.fbBelowEntry = 1'b0;
        rampCyc = 16'h0000;
        cmp.fbAboveResume = 1'b1;
        gateHigh(w);
        cmp.fbAboveResume = 1'b0;
        check(biasEn, 1'b1);
        check(w, 32'h4B1);
        gateLow(l);
        check(w + l, 32'h963);
        rampCyc = 16'h0064;
        gateHigh(w);
        check(w inside {[32'h64:32'h96]}, 1'b1);
        cmp.fbBelowPause = 1'b1;
        tick(8);
        cmp.fbBelowPause = 1'b0;
        check(st, 7'h0C);
        n = 0;
        repeat (3000) begin
            tick(1);
            if (gateOn !== 1'b0)
                n++;
        end
        check(n, 32'h0);
        cmp.fbAboveExit = 1'b1;
        tick(8);
        cmp.fbAboveExit = 1'b0;
        check(st, 7'h10);
        check(udCount, 3'h1);
        pulseOn();
        gateHigh(w);
        check(w >= 32'hC8, 1'b1);
    endtask

    task automatic sLatch();
        cmp.zcOverVolt = 1'b1;
        tick(100);
        check(latchedOff, 1'b0);
        tick(50);
        check({gateOn, latchedOff}, 2'h1);
        cmp.zcOverVolt = 1'b0;
        cmp.supplyAboveOn = 1'b0;
        cmp.supplyUnder = 1'b1;
        tick(8);
        check({startupEn, latchedOff}, 2'h3);
        cmp.supplyUnder = 1'b0;
        cmp.supplyAboveOn = 1'b1;
        tick(8);
        check({gateOn, startupEn, latchedOff}, 3'h1);
        doReset();
        powerUp();
        rampCyc = 16'h0000;
        shortWind = 1'b1;
        pulseOn();
        tick(40);
        shortWind = 1'b0;
        check({gateOn, latchedOff}, 2'h1);
    endtask

    ////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        err_total = 0;
        checks = 0;
        zcTurnOn = 1'b0;
        cntUp = 1'b0;
        cntDown = 1'b0;
        rampCyc = 16'h0000;
        shortWind = 1'b0;
        doReset();
        powerUp();
        sMaxOn();
        sFaults();
        sBurst();
        sLatch();
        end_of_test();
    end

    // Watchdog: about five times the expected run length
    initial begin
        #400000;
        err_total++;
        end_of_test();
    end

endmodule // tb_top
